// [core/its_regs.vh]
// Constants for the interval timer signal unit: command codes, time base and limits.
// Assumes a 20 MHz system clock; all counts are derived from the figures below.
`ifndef ITS_REGS_VH
`define ITS_REGS_VH

// Command words carried in the first field of the command parameter block.
`define ITS_CMD_ONE_SHOT    32'h00001000
`define ITS_CMD_PERIODIC    32'h00001001
`define ITS_CMD_FREE_RUN    32'h00001002
`define ITS_CMD_HALT        32'h00001003
`define ITS_CMD_CLEAR_HALT  32'h00001004
`define ITS_CMD_STATUS      32'h0000001C

// Time base.
`define ITS_CLK_PERIOD_NS   50
`define ITS_UNIT_US         100
`define ITS_UNIT_CYC        ((`ITS_UNIT_US * 1000) / `ITS_CLK_PERIOD_NS)

// Period limits in timer units (least time rounds up).
`define ITS_MIN_PERIOD_US   500
`define ITS_MIN_PERIOD      ((`ITS_MIN_PERIOD_US + `ITS_UNIT_US - 1) / `ITS_UNIT_US)
`define ITS_MAX_16          32'h0000FFFF
`define ITS_MAX_32          32'hFFFFFFFF

// Timer population: the first ones are 16-bit, the rest 32-bit.
`define ITS_NUM_TIMERS      6
`define ITS_NUM_16          4

// Mode state encodings, one-hot.
`define ITS_ST_HALT         4'h1
`define ITS_ST_FREE         4'h2
`define ITS_ST_ONE          4'h4
`define ITS_ST_CYC          4'h8

`endif

// [core/its_timer.v]
// One interval timer channel counting in 100 us units.
// Assumes a one-cycle unit tick from the parent and one command strobe at a time.
`include "its_regs.vh"

module its_timer #(
  parameter [31:0] MAX_COUNT = `ITS_MAX_16
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  // Time base
  input  wire        unit_tick,
  // Command
  input  wire        cmd_we,
  input  wire [31:0] cmd_code,
  input  wire [31:0] cmd_sig,
  input  wire [31:0] cmd_period,
  output wire        cmd_bad,
  // Signal delivery
  input  wire        fire_ack,
  output reg         fire_r,
  output reg  [31:0] fire_code_r,
  // State
  output reg  [31:0] value_r,
  output reg  [3:0]  mode_r,
  output reg  [31:0] sig_r,
  output reg  [31:0] period_r
);

  localparam ST_HALT = `ITS_ST_HALT;
  localparam ST_FREE = `ITS_ST_FREE;
  localparam ST_ONE  = `ITS_ST_ONE;
  localparam ST_CYC  = `ITS_ST_CYC;
  localparam [31:0] MIN_PERIOD = `ITS_MIN_PERIOD;

  wire        is_sig  = (cmd_code == `ITS_CMD_ONE_SHOT) || (cmd_code == `ITS_CMD_PERIODIC);
  wire        known   = is_sig || (cmd_code == `ITS_CMD_FREE_RUN) || (cmd_code == `ITS_CMD_HALT) ||
                        (cmd_code == `ITS_CMD_CLEAR_HALT);
  wire [31:0] value_inc = value_r + 32'h00000001;
  wire        elapsed   = (value_inc == period_r);

  // A period out of range is refused and leaves the timer untouched.
  assign cmd_bad = !known || (is_sig && ((cmd_period < MIN_PERIOD) || (cmd_period > MAX_COUNT)));

  always @(posedge clk_sys) begin
    if (rst) begin
      value_r     <= 32'h00000000;
      mode_r      <= ST_HALT;
      sig_r       <= 32'h00000000;
      period_r    <= 32'h00000000;
      fire_r      <= 1'b0;
      fire_code_r <= 32'h00000000;
    end else if (ce) begin
      // The acknowledge is placed first so that a new expiry in the same cycle wins.
      if (fire_ack) begin
        fire_r <= 1'b0;
      end
      if (cmd_we && !cmd_bad) begin
        case (cmd_code)
          `ITS_CMD_ONE_SHOT, `ITS_CMD_PERIODIC: begin
            value_r  <= 32'h00000000;
            period_r <= cmd_period;
            sig_r    <= cmd_sig;
            fire_r   <= 1'b0;
            if (cmd_sig == 32'h00000000) begin
              mode_r <= ST_FREE;
            end else if (cmd_code == `ITS_CMD_ONE_SHOT) begin
              mode_r <= ST_ONE;
            end else begin
              mode_r <= ST_CYC;
            end
          end
          `ITS_CMD_FREE_RUN: begin
            mode_r   <= ST_FREE;
            sig_r    <= 32'h00000000;
            period_r <= 32'h00000000;
            fire_r   <= 1'b0;
          end
          `ITS_CMD_HALT: begin
            mode_r   <= ST_HALT;
            sig_r    <= 32'h00000000;
            period_r <= 32'h00000000;
            fire_r   <= 1'b0;
          end
          default: begin
            mode_r   <= ST_HALT;
            value_r  <= 32'h00000000;
            sig_r    <= 32'h00000000;
            period_r <= 32'h00000000;
            fire_r   <= 1'b0;
          end
        endcase
      end else if (unit_tick) begin
        case (mode_r)
          ST_FREE: begin
            value_r <= (value_r == MAX_COUNT) ? 32'h00000000 : value_inc;
          end
          ST_ONE: begin
            value_r <= value_inc;
            if (elapsed) begin
              fire_r      <= 1'b1;
              fire_code_r <= sig_r;
              mode_r      <= ST_FREE;
              sig_r       <= 32'h00000000;
              period_r    <= 32'h00000000;
            end
          end
          ST_CYC: begin
            if (elapsed) begin
              value_r     <= 32'h00000000;
              fire_r      <= 1'b1;
              fire_code_r <= sig_r;
            end else begin
              value_r <= value_inc;
            end
          end
          default: begin
            value_r <= value_r;
          end
        endcase
      end
    end
  end

endmodule

// [core/its_top.v]
// Interval timer signal unit: six interval timers, a command port and the mains-derived system tick.
// Assumes all inputs are synchronous to clk_sys and that commands are not offered while busy.
`include "its_regs.vh"

module its_top (
  // Clock, reset, enable
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  // Mains line sync
  input  wire        mains_sync_input,
  output reg         os_tick_r,
  // Command parameter block
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_sel,
  input  wire [31:0] cmd_code,
  input  wire [31:0] cmd_param1,
  input  wire [31:0] cmd_param2,
  output reg         cmd_ack_r,
  output reg         cmd_err_r,
  output reg         cmd_busy_r,
  // Status words
  output reg         stat_valid_r,
  output reg  [1:0]  stat_idx_r,
  output reg  [31:0] stat_word_r,
  // Delivered signals
  output reg         sig_valid_r,
  output reg  [2:0]  sig_timer_r,
  output reg  [31:0] sig_code_r
);

  localparam NT = `ITS_NUM_TIMERS;
  localparam integer PRE_LAST_I = `ITS_UNIT_CYC - 1;
  localparam [10:0]  PRE_LAST   = PRE_LAST_I[10:0];

  reg         sync_prev_r;
  reg  [10:0] pre_r;
  reg         unit_tick_r;
  reg  [127:0] snap_r;
  reg  [1:0]  emit_cnt_r;

  wire [NT*32-1:0] value_w;
  wire [NT*32-1:0] sig_w;
  wire [NT*32-1:0] period_w;
  wire [NT*32-1:0] fcode_w;
  wire [NT*4-1:0]  mode_w;
  wire [NT-1:0]    fire_w;
  wire [NT-1:0]    bad_w;
  wire [NT-1:0]    ack_w;
  wire [NT-1:0]    we_w;

  // A command offered while busy gets no answer at all; the sender must wait for cmd_busy_r low.
  wire accept    = cmd_valid && !cmd_busy_r;
  wire sel_ok    = (cmd_sel < NT);
  wire is_status = (cmd_code == `ITS_CMD_STATUS);

  // Lowest-numbered expired timer is served first; others wait one cycle each.
  reg  [2:0] srv_sel;
  integer    k;
  always @* begin
    srv_sel = 3'h0;
    for (k = NT - 1; k >= 0; k = k - 1) begin
      if (fire_w[k]) begin
        srv_sel = k[2:0];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NT; i = i + 1) begin : g_tmr
      assign we_w[i]  = accept && sel_ok && !is_status && (cmd_sel == i);
      assign ack_w[i] = fire_w[i] && (srv_sel == i);
      its_timer #(
        .MAX_COUNT (i < `ITS_NUM_16 ? `ITS_MAX_16 : `ITS_MAX_32)
      ) u_tmr (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .ce          (ce),
        .unit_tick   (unit_tick_r),
        .cmd_we      (we_w[i]),
        .cmd_code    (cmd_code),
        .cmd_sig     (cmd_param1),
        .cmd_period  (cmd_param2),
        .cmd_bad     (bad_w[i]),
        .fire_ack    (ack_w[i]),
        .fire_r      (fire_w[i]),
        .fire_code_r (fcode_w[i*32 +: 32]),
        .value_r     (value_w[i*32 +: 32]),
        .mode_r      (mode_w[i*4 +: 4]),
        .sig_r       (sig_w[i*32 +: 32]),
        .period_r    (period_w[i*32 +: 32])
      );
    end
  endgenerate

  // Status fields of the selected timer.
  wire [3:0]  q_mode   = mode_w[cmd_sel*4 +: 4];
  wire        q_sigmod = (q_mode == `ITS_ST_ONE) || (q_mode == `ITS_ST_CYC);
  reg  [31:0] q_code;
  wire [31:0] q_sig    = q_sigmod ? sig_w[cmd_sel*32 +: 32]    : 32'h00000000;
  wire [31:0] q_period = q_sigmod ? period_w[cmd_sel*32 +: 32] : 32'h00000000;

  // The mode word reuses the command word named for that mode, whatever command put the timer there; halt covers any other state.
  always @* begin
    case (q_mode)
      `ITS_ST_ONE: begin
        q_code = `ITS_CMD_ONE_SHOT;
      end
      `ITS_ST_CYC: begin
        q_code = `ITS_CMD_PERIODIC;
      end
      `ITS_ST_FREE: begin
        q_code = `ITS_CMD_FREE_RUN;
      end
      default: begin
        q_code = `ITS_CMD_HALT;
      end
    endcase
  end

  // Mains edge detector.
  always @(posedge clk_sys) begin
    if (rst) begin
      sync_prev_r <= 1'b0;
      os_tick_r   <= 1'b0;
    end else if (ce) begin
      // Both edges of the mains sync give 120 ticks per second from 60 Hz.
      sync_prev_r <= mains_sync_input;
      os_tick_r   <= mains_sync_input ^ sync_prev_r;
    end
  end

  // Unit prescaler runs free from reset, so the first unit after a command may be short.
  always @(posedge clk_sys) begin
    if (rst) begin
      pre_r       <= 11'h000;
      unit_tick_r <= 1'b0;
    end else if (ce) begin
      if (pre_r == PRE_LAST) begin
        pre_r       <= 11'h000;
        unit_tick_r <= 1'b1;
      end else begin
        pre_r       <= pre_r + 11'h001;
        unit_tick_r <= 1'b0;
      end
    end
  end

  // Command answer.
  always @(posedge clk_sys) begin
    if (rst) begin
      cmd_ack_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end else if (ce) begin
      cmd_ack_r <= accept;
      cmd_err_r <= accept && (!sel_ok || (!is_status && bad_w[cmd_sel]));
    end
  end

  // Signal delivery.
  always @(posedge clk_sys) begin
    if (rst) begin
      sig_valid_r <= 1'b0;
      sig_timer_r <= 3'h0;
      sig_code_r  <= 32'h00000000;
    end else if (ce) begin
      sig_valid_r <= |fire_w;
      if (|fire_w) begin
        sig_timer_r <= srv_sel;
        sig_code_r  <= fcode_w[srv_sel*32 +: 32];
      end
    end
  end

  // Status words leave in fixed order, one per cycle, while new commands are held off.
  always @(posedge clk_sys) begin
    if (rst) begin
      cmd_busy_r   <= 1'b0;
      snap_r       <= 128'h0;
      emit_cnt_r   <= 2'h0;
      stat_valid_r <= 1'b0;
      stat_idx_r   <= 2'h0;
      stat_word_r  <= 32'h00000000;
    end else if (ce) begin
      if (accept && is_status && sel_ok) begin
        // A query taken right after the last word must not leave that word marked valid.
        cmd_busy_r   <= 1'b1;
        snap_r       <= {value_w[cmd_sel*32 +: 32], q_code, q_sig, q_period};
        emit_cnt_r   <= 2'h0;
        stat_valid_r <= 1'b0;
      end else if (cmd_busy_r) begin
        stat_valid_r <= 1'b1;
        stat_idx_r   <= emit_cnt_r;
        stat_word_r  <= snap_r[127:96];
        snap_r       <= {snap_r[95:0], 32'h00000000};
        emit_cnt_r   <= emit_cnt_r + 2'h1;
        if (emit_cnt_r == 2'h3) begin
          cmd_busy_r <= 1'b0;
        end
      end else begin
        stat_valid_r <= 1'b0;
      end
    end
  end

endmodule

// [tb/its_props.sv]
// Checker for its_top: command, status and system tick timing at the ports.
// Assumes it is bound to its_top and sees only that module's ports.
module its_props (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  input wire        ce,
  // Mains sync
  input wire        mains_sync_input,
  input wire        os_tick_r,
  // Command
  input wire        cmd_valid,
  input wire [2:0]  cmd_sel,
  input wire [31:0] cmd_code,
  input wire [31:0] cmd_param2,
  input wire        cmd_ack_r,
  input wire        cmd_err_r,
  input wire        cmd_busy_r,
  // Status and signals
  input wire        stat_valid_r,
  input wire [1:0]  stat_idx_r,
  input wire [31:0] stat_word_r,
  input wire        sig_valid_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = ce && cmd_valid && !cmd_busy_r;
  wire set_cmd = cmd_code == 32'h1000 || cmd_code == 32'h1001;
  a_tick_edge: assert property (ce && mains_sync_input != $past(mains_sync_input) |=> os_tick_r)
    else $error("tick missing after sync edge");
  a_tick_quiet: assert property (ce && $stable(mains_sync_input) |=> !os_tick_r)
    else $error("tick without sync edge");
  a_ack_taken: assert property (take |=> cmd_ack_r)
    else $error("command not acknowledged");
  a_ack_cause: assert property (cmd_ack_r |-> $past(cmd_valid) && !$past(cmd_busy_r))
    else $error("acknowledge without command");
  a_period_err: assert property (take && set_cmd && cmd_sel < 3'h6 && (cmd_param2 < 32'h5 ||
    cmd_sel < 3'h4 && cmd_param2 > 32'hFFFF) |=> cmd_ack_r && cmd_err_r)
    else $error("bad period accepted");
  a_err_ack: assert property (cmd_err_r |-> cmd_ack_r)
    else $error("error without acknowledge");
  a_status_seq: assert property (take && cmd_code == 32'h1C && cmd_sel < 3'h6 |=> cmd_busy_r ##1
    stat_valid_r && stat_idx_r == 2'h0 ##1 stat_idx_r == 2'h1 ##1 stat_idx_r == 2'h2 ##1
    stat_idx_r == 2'h3 && !cmd_busy_r ##1 !stat_valid_r)
    else $error("status word sequence wrong");
  a_mode_word: assert property (stat_valid_r && stat_idx_r == 2'h1 |->
    stat_word_r >= 32'h1000 && stat_word_r <= 32'h1003)
    else $error("mode word out of range");
  a_idle_zero: assert property (stat_valid_r && stat_idx_r == 2'h2 && $past(stat_word_r) > 32'h1001 |->
    stat_word_r == 32'h0 ##1 stat_word_r == 32'h0)
    else $error("signal or period not zero when idle");
  c_status: cover property (stat_valid_r && stat_idx_r == 2'h3);
  c_sig: cover property (sig_valid_r);
  c_err: cover property (cmd_err_r);
endmodule

bind its_top its_props u_props (.*);

// [tb/testbench.sv]
// Self-checking bench for its_top: random mains edges, timer commands and status reads.
// Assumes the fixed 2000-cycle unit prescaler at 20 MHz, so one unit is 2000 cycles.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        mains_sync_input = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_sel = 3'h0;
  logic [31:0] cmd_code = 32'h0, cmd_param1 = 32'h0, cmd_param2 = 32'h0;
  wire         os_tick_r, cmd_ack_r, cmd_err_r, cmd_busy_r, stat_valid_r, sig_valid_r;
  wire [1:0]   stat_idx_r;
  wire [2:0]   sig_timer_r;
  wire [31:0]  stat_word_r, sig_code_r;
  int          miscompares = 0, n_checks = 0, cyc;
  logic [31:0] st [4];
  logic [31:0] code;
  logic        prev = 1'b0;
  always #25 clk_sys = ~clk_sys;
  its_top uut (.*);
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function logic perr(input logic [2:0] s, input logic [31:0] c, p);
    return s > 3'h5 || !(c inside {[32'h1000:32'h1004], 32'h1C}) ||
      ((c == 32'h1000 || c == 32'h1001) && (p < 32'h5 || s < 3'h4 && p > 32'hFFFF));
  endfunction
  task cmd(input logic [2:0] s, input logic [31:0] c, p1, p2);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_sel = s;
    cmd_code = c;
    cmd_param1 = p1;
    cmd_param2 = p2;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    chk("ack", cmd_ack_r, 1'b1);
    chk("err", cmd_err_r, perr(s, c, p2));
  endtask
  task stat(input logic [2:0] s);
    cmd(s, 32'h1C, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      chk("idx", stat_idx_r, i);
      st[i] = stat_word_r;
    end
  endtask
  task sx(input logic [31:0] ev, em, es, ep);
    chk("value", st[0], ev);
    chk("mode", st[1], em);
    chk("signal", st[2], es);
    chk("period", st[3], ep);
  endtask
  // A missing expected signal ends the run, since later steps depend on its timing.
  task wsig(input int lim, input bit want);
    cyc = 0;
    do begin
      @(negedge clk_sys);
      cyc++;
    end while (cyc < lim && sig_valid_r !== 1'b1);
    if (want && cyc == lim) begin
      miscompares++;
      $display("BAD wait exp signal seen none");
      end_sim;
    end
  endtask
  initial begin
    void'($urandom(1));
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    stat(3'h0);
    sx(32'h0, 32'h1003, 32'h0, 32'h0);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_sys);
      chk("tick", os_tick_r, mains_sync_input != prev);
      prev = mains_sync_input;
      mains_sync_input = 1'($urandom_range(1));
    end
    cmd(3'h0, 32'h1000, 32'h7, 32'h4);
    cmd(3'h0, 32'h1001, 32'h7, 32'h10000);
    cmd(3'h6, 32'h1001, 32'h7, 32'h5);
    cmd(3'h0, 32'h1005, 32'h0, 32'h0);
    stat(3'h0);
    sx(32'h0, 32'h1003, 32'h0, 32'h0);
    code = $urandom() | 32'h1;
    cmd(3'h1, 32'h1001, code, 32'h5);
    stat(3'h1);
    sx(32'h0, 32'h1001, code, 32'h5);
    wsig(10005, 1'b1);
    chk("timer", sig_timer_r, 3'h1);
    chk("code", sig_code_r, code);
    wsig(10005, 1'b1);
    chk("interval", cyc, 10000);
    repeat (4500) @(negedge clk_sys);
    cmd(3'h1, 32'h1003, 32'h0, 32'h0);
    stat(3'h1);
    sx(32'h2, 32'h1003, 32'h0, 32'h0);
    repeat (4000) @(negedge clk_sys);
    stat(3'h1);
    sx(32'h2, 32'h1003, 32'h0, 32'h0);
    cmd(3'h1, 32'h1002, 32'h0, 32'h0);
    stat(3'h1);
    sx(32'h2, 32'h1002, 32'h0, 32'h0);
    wsig(12000, 1'b0);
    chk("quiet", cyc, 12000);
    cmd(3'h1, 32'h1004, 32'h0, 32'h0);
    stat(3'h1);
    sx(32'h0, 32'h1003, 32'h0, 32'h0);
    code = $urandom() | 32'h1;
    cmd(3'h4, 32'h1000, code, 32'h5);
    wsig(10005, 1'b1);
    chk("timer", sig_timer_r, 3'h4);
    chk("code", sig_code_r, code);
    wsig(12000, 1'b0);
    chk("quiet", cyc, 12000);
    stat(3'h4);
    chk("mode", st[1], 32'h1002);
    cmd(3'h2, 32'h1001, 32'h5, 32'h5);
    cmd(3'h2, 32'h1001, 32'h0, 32'h5);
    stat(3'h2);
    sx(32'h0, 32'h1002, 32'h0, 32'h0);
    wsig(12000, 1'b0);
    chk("quiet", cyc, 12000);
    end_sim;
  end
endmodule
